// >>> fdc_port_pkg.sv
// shared constants, types and helpers for the floppy host port block
package fdc_port_pkg;

  // ****************************************
  // operations register field positions
  // ****************************************
  localparam int OR_DRIVE_CHOICE   = 0;  // drive_choice_bit
  localparam int OR_SELECT_GATE    = 1;  // must be 0 for drive selects
  localparam int OR_SOFT_RESET_N   = 2;  // soft_reset_n, active low
  localparam int OR_DMA_QUALIFY    = 3;  // dma_qualify_enable
  localparam int OR_MOTOR_FIRST    = 4;  // motor_enable_first
  localparam int OR_MOTOR_SECOND   = 5;  // motor_enable_second
  localparam int OR_MODE_CHOICE    = 7;  // mode_choice_bit

  // reset value: soft reset active, compat chosen, motors off
  localparam logic [7:0] OP_REG_RESET   = 8'h00;

  // mode switch patterns: 1X00X0XX and 0X00X0XX
  localparam logic [7:0] MODE_PAT_MASK   = 8'hB4;
  localparam logic [7:0] MODE_PAT_SPECIAL = 8'h80;
  localparam logic [7:0] MODE_PAT_COMPAT  = 8'h00;

  // register select decode values
  localparam logic REG_SEL_STATUS = 1'b0;
  localparam logic REG_SEL_DATA   = 1'b1;

  // ****************************************
  // timing
  // ****************************************
  localparam int unsigned CLK_PERIOD_NS       = 4;
  localparam int unsigned POLL_PERIOD_NS      = 1024000;  // 1.024 ms
  localparam int unsigned POLL_PERIOD_MINI_NS = 2048000;  // 2.048 ms
  localparam int unsigned NUM_DRIVES          = 4;
  localparam int          POLL_CNT_W          = 20;

  // ****************************************
  // types
  // ****************************************
  typedef enum {
    st_post_reset,  // after hardware reset, waiting for first access
    st_base,
    st_special,
    st_compat
  } mode_t;

  // host strobes, all active low except the select line
  typedef struct packed {
    logic cs_n;
    logic rd_n;
    logic wr_n;
    logic reg_select_line;
    logic op_reg_load_strobe_n;
    logic ctrl_reg_load_strobe_n;
  } host_bus_t;

  // ****************************************
  // helpers
  // ****************************************
  // one-hot decode of a two-bit drive number
  function automatic logic [3:0] one_hot(input logic [1:0] unit);
    one_hot = 4'h1 << unit;
  endfunction

  // polling slot to drive number, order is drive 1-2-4-3
  function automatic logic [1:0] poll_order(input logic [1:0] slot);
    unique case (slot)
      2'h0: poll_order = 2'h0;
      2'h1: poll_order = 2'h1;
      2'h2: poll_order = 2'h3;
      2'h3: poll_order = 2'h2;
    endcase
  endfunction

endpackage

// >>> op_register.sv
// eight-bit write-only operations register with its load pulse
module op_register
  import fdc_port_pkg::*;
(
  input  wire logic       core_clk_in,
  input  wire logic       resetn_in,
  input  wire logic       load_in,      // one-cycle load pulse
  input  wire logic [7:0] data_in,      // host data bus
  output logic      [7:0] op_reg_out    // current register contents
);

  // ****************************************
  // register storage
  // ****************************************
  // only the hardware reset clears it; soft reset lives in bit 2
  // and must not wipe the register that commands it
  always_ff @(posedge core_clk_in or negedge resetn_in) begin
    if (!resetn_in) begin
      op_reg_out <= OP_REG_RESET;
    end else if (load_in) begin
      op_reg_out <= data_in;
    end
  end

endmodule

// >>> drive_poll_timer.sv
// ready-line polling sequencer: steps over the four drives in turn
module drive_poll_timer
  import fdc_port_pkg::*;
#(
  parameter int unsigned STEP_CYCLES      = 64000,
  parameter int unsigned STEP_CYCLES_MINI = 128000
)(
  input  wire logic       core_clk_in,
  input  wire logic       resetn_in,
  input  wire logic       restart_in,       // pulse: reset just released
  input  wire logic       enable_in,        // idle, no read/write command
  input  wire logic       mini_in,          // mini-floppy polling rate
  output logic            poll_active_out,  // polling owns the selects
  output logic      [1:0] poll_drive_out,   // drive being polled
  output logic            ready_change_out  // pulse: not-ready to ready
);

  logic [POLL_CNT_W-1:0] tick_count;     // cycles within one slot
  logic [1:0]            slot;           // slot in the 1-2-4-3 order
  logic                  ready_pending;  // first round after reset
  logic [POLL_CNT_W-1:0] step_limit;     // last count of a slot

  // slot length; each drive comes round once per full period
  assign step_limit = mini_in ? POLL_CNT_W'(STEP_CYCLES_MINI - 1)
                              : POLL_CNT_W'(STEP_CYCLES - 1);

  // ****************************************
  // slot counter
  // ****************************************
  // reset forces not-ready, so the first full round after it sees
  // every drive turn ready; that is the only change ever reported
  always_ff @(posedge core_clk_in or negedge resetn_in) begin
    if (!resetn_in) begin
      tick_count       <= '0;
      slot             <= 2'h0;
      ready_pending    <= 1'b1;
      ready_change_out <= 1'b0;
    end else begin
      ready_change_out <= 1'b0;
      if (restart_in) begin
        tick_count    <= '0;
        slot          <= 2'h0;
        ready_pending <= 1'b1;
      end else if (enable_in) begin
        if (tick_count >= step_limit) begin
          tick_count <= '0;
          slot       <= slot + 2'h1;
          if (slot == 2'h3 && ready_pending) begin
            ready_pending    <= 1'b0;
            ready_change_out <= 1'b1;
          end
        end else begin
          tick_count <= tick_count + POLL_CNT_W'(1);
        end
      end
    end
  end

  // ****************************************
  // registered outputs
  // ****************************************
  always_ff @(posedge core_clk_in or negedge resetn_in) begin
    if (!resetn_in) begin
      poll_active_out <= 1'b0;
      poll_drive_out  <= 2'h0;
    end else begin
      poll_active_out <= enable_in;
      poll_drive_out  <= poll_order(slot);
    end
  end

endmodule

// >>> fdc_host_port.sv
// host register port and operating-mode control of the floppy controller
module fdc_host_port
  import fdc_port_pkg::*;
#(
  parameter int unsigned POLL_STEP_CYCLES =
    POLL_PERIOD_NS / (NUM_DRIVES * CLK_PERIOD_NS),
  parameter int unsigned POLL_STEP_CYCLES_MINI =
    POLL_PERIOD_MINI_NS / (NUM_DRIVES * CLK_PERIOD_NS)
)(
  input  wire logic       core_clk_in,
  input  wire logic       resetn_in,
  // host side
  input  wire host_bus_t  host_bus_in,          // strobes and select
  input  wire logic [7:0] data_in,              // host data bus in
  output logic      [7:0] data_out,             // host data bus out
  output logic            data_oe_out,          // drive the data bus
  output logic            dma_req_out,          // qualified dma request
  output logic            dma_req_oe_out,       // dma request driven
  output logic            irq_out,              // qualified interrupt
  output logic            irq_oe_out,           // interrupt driven
  input  wire logic       dack_n_in,            // dma acknowledge
  // controller core side
  input  wire logic [7:0] main_status_in,       // main status byte
  input  wire logic [7:0] result_byte_in,       // byte for host reads
  output logic      [7:0] cmd_byte_out,         // byte the host wrote
  output logic            cmd_byte_valid_out,   // pulse: byte written
  output logic            data_read_out,        // pulse: byte read
  input  wire logic       core_dma_req_in,      // raw dma request
  input  wire logic       core_irq_in,          // raw interrupt
  output logic            dack_n_out,           // qualified acknowledge
  output logic            controller_reset_out, // hold core in reset
  output logic            ready_change_out,     // pulse: drives ready
  input  wire logic       core_idle_in,         // between commands
  input  wire logic       rw_command_in,        // read/write running
  input  wire logic       mini_floppy_in,       // slower polling
  input  wire logic [1:0] unit_select_in,       // unit from command
  input  wire logic       precomp_needed_in,    // precompensation on
  input  wire logic       slow_spindle_req_in,  // ask for slow spindle
  // drive side
  output logic      [3:0] drive_select_outputs, // active high selects
  output logic            motor_on_first_n_out,
  output logic            motor_on_second_n_out,
  output logic            reduced_write_current_pin_out,
  output logic      [1:0] mode_out              // 0 post,1 base,2 sp,3 co
);

  // ****************************************
  // declarations
  // ****************************************
  host_bus_t   prev_bus;        // strobes one cycle back
  logic        rd_start;        // read strobe just went low
  logic        wr_start;        // write strobe just went low
  logic        chip_read;       // read of status or data register
  logic        chip_write;      // write of data register
  logic        op_load;         // operations register load pulse
  logic        ctrl_read;       // control register read pulse
  logic        any_access;      // any host touch of the chip
  logic [7:0]  op_reg;          // operations register contents
  mode_t       mode;            // current operating mode
  mode_t       next_mode;       // mode after this cycle
  logic        soft_reset;      // controller held in reset
  logic        prev_soft_reset; // for the release edge
  logic        poll_restart;    // pulse: reset released
  logic        poll_active;     // polling owns the selects
  logic [1:0]  poll_drive;      // drive being polled
  logic        ready_change;    // ready change pulse from poller
  logic        qualify;         // enable gate for dma and irq
  logic [3:0]  next_selects;    // drive select value to register

  // ****************************************
  // strobe edge detection
  // ****************************************
  // strobes are synchronous; act once per access on the falling
  // edge so a long strobe does not repeat a data register load
  always_ff @(posedge core_clk_in or negedge resetn_in) begin
    if (!resetn_in) begin
      prev_bus <= '1;
    end else begin
      prev_bus <= host_bus_in;
    end
  end

  assign rd_start = prev_bus.rd_n & ~host_bus_in.rd_n;
  assign wr_start = prev_bus.wr_n & ~host_bus_in.wr_n;

  // both strobes at once, or a status write, moves no data but still counts in any_access
  assign chip_read  = ~host_bus_in.cs_n & rd_start
                    & host_bus_in.wr_n;
  assign chip_write = ~host_bus_in.cs_n & wr_start
                    & host_bus_in.rd_n
                    & (host_bus_in.reg_select_line == REG_SEL_DATA);
  assign op_load    = ~host_bus_in.op_reg_load_strobe_n
                    & wr_start & host_bus_in.rd_n;
  assign ctrl_read  = ~host_bus_in.ctrl_reg_load_strobe_n
                    & rd_start & host_bus_in.wr_n;
  assign any_access = chip_read | chip_write | op_load | ctrl_read
                    | (~host_bus_in.cs_n & wr_start);

  // ****************************************
  // operations register
  // ****************************************
  op_register u_op_register (
    .core_clk_in (core_clk_in),
    .resetn_in   (resetn_in),
    .load_in     (op_load),
    .data_in     (data_in),
    .op_reg_out  (op_reg)
  );

  // ****************************************
  // mode selection
  // ****************************************
  always_comb begin
    next_mode = mode;
    unique case (mode)
      st_post_reset: begin
        // an operations write wins over plain base entry
        if (op_load) begin
          next_mode = st_compat;
        end else if (any_access) begin
          next_mode = st_base;
        end
      end
      st_base: begin
        if (op_load) begin
          next_mode = st_compat;
        end
      end
      st_special: begin
        // mode choice only counts while soft reset is held
        if (ctrl_read &&
            (op_reg & MODE_PAT_MASK) == MODE_PAT_COMPAT) begin
          next_mode = st_compat;
        end
      end
      st_compat: begin
        if (ctrl_read &&
            (op_reg & MODE_PAT_MASK) == MODE_PAT_SPECIAL) begin
          next_mode = st_special;
        end
      end
    endcase
  end

  // only the hardware reset returns to the post-reset state;
  // soft reset never touches the mode register
  always_ff @(posedge core_clk_in or negedge resetn_in) begin
    if (!resetn_in) begin
      mode <= st_post_reset;
    end else begin
      mode <= next_mode;
    end
  end

  // ****************************************
  // soft reset
  // ****************************************
  // held from hardware reset until the first access; in base the
  // register is ignored so software cannot reset the core
  always_comb begin
    unique case (mode)
      st_post_reset: soft_reset = 1'b1;
      st_base:       soft_reset = 1'b0;
      st_special,
      st_compat:     soft_reset = ~op_reg[OR_SOFT_RESET_N];
    endcase
  end

  always_ff @(posedge core_clk_in or negedge resetn_in) begin
    if (!resetn_in) begin
      prev_soft_reset      <= 1'b1;
      controller_reset_out <= 1'b1;
    end else begin
      prev_soft_reset      <= soft_reset;
      controller_reset_out <= soft_reset;
    end
  end

  // release of either reset kicks the polling routine
  assign poll_restart = prev_soft_reset & ~soft_reset;

  // ****************************************
  // drive ready polling
  // ****************************************
  drive_poll_timer #(
    .STEP_CYCLES      (POLL_STEP_CYCLES),
    .STEP_CYCLES_MINI (POLL_STEP_CYCLES_MINI)
  ) u_drive_poll_timer (
    .core_clk_in      (core_clk_in),
    .resetn_in        (resetn_in),
    .restart_in       (poll_restart),
    .enable_in        (core_idle_in & ~rw_command_in & ~soft_reset),
    .mini_in          (mini_floppy_in),
    .poll_active_out  (poll_active),
    .poll_drive_out   (poll_drive),
    .ready_change_out (ready_change)
  );

  // ****************************************
  // host data bus
  // ****************************************
  // the bus is driven only while a legal read is in progress
  always_ff @(posedge core_clk_in or negedge resetn_in) begin
    if (!resetn_in) begin
      data_out    <= 8'h00;
      data_oe_out <= 1'b0;
    end else begin
      data_oe_out <= ~host_bus_in.cs_n & ~host_bus_in.rd_n
                   & host_bus_in.wr_n;
      if (host_bus_in.reg_select_line == REG_SEL_STATUS) begin
        data_out <= main_status_in;
      end else begin
        data_out <= result_byte_in;
      end
    end
  end

  // ****************************************
  // data register toward the core
  // ****************************************
  always_ff @(posedge core_clk_in or negedge resetn_in) begin
    if (!resetn_in) begin
      cmd_byte_out       <= 8'h00;
      cmd_byte_valid_out <= 1'b0;
      data_read_out      <= 1'b0;
    end else begin
      cmd_byte_valid_out <= chip_write;
      data_read_out      <= chip_read
                          & (host_bus_in.reg_select_line == REG_SEL_DATA);
      if (chip_write) begin
        cmd_byte_out <= data_in;
      end
    end
  end

  // ****************************************
  // dma and interrupt qualification
  // ****************************************
  // base mode has no gate at all; other modes use the enable bit
  assign qualify = (mode == st_base) | op_reg[OR_DMA_QUALIFY];

  always_ff @(posedge core_clk_in or negedge resetn_in) begin
    if (!resetn_in) begin
      dma_req_out      <= 1'b0;
      irq_out          <= 1'b0;
      dma_req_oe_out   <= 1'b0;
      irq_oe_out       <= 1'b0;
      dack_n_out       <= 1'b1;
      ready_change_out <= 1'b0;
    end else begin
      dma_req_out      <= core_dma_req_in & qualify;
      irq_out          <= core_irq_in & qualify;
      dack_n_out       <= dack_n_in | ~qualify;
      // tristated until the first access leaves post-reset
      dma_req_oe_out   <= (mode != st_post_reset);
      irq_oe_out       <= (mode != st_post_reset);
      ready_change_out <= ready_change;
    end
  end

  // ****************************************
  // drive select, motor and write-current pins
  // ****************************************
  // in compat the user never sees polling on the selects
  always_comb begin
    next_selects = 4'h0;
    if (mode == st_compat) begin
      if (!op_reg[OR_SELECT_GATE]) begin
        next_selects[0] = ~op_reg[OR_DRIVE_CHOICE]
                        & op_reg[OR_MOTOR_FIRST];
        next_selects[1] = op_reg[OR_DRIVE_CHOICE]
                        & op_reg[OR_MOTOR_SECOND];
      end
    end else if (poll_active) begin
      next_selects = one_hot(poll_drive);
    end else begin
      next_selects = one_hot(unit_select_in);
    end
  end

  always_ff @(posedge core_clk_in or negedge resetn_in) begin
    if (!resetn_in) begin
      drive_select_outputs          <= 4'h0;
      motor_on_first_n_out          <= 1'b1;
      motor_on_second_n_out         <= 1'b1;
      reduced_write_current_pin_out <= 1'b0;
    end else begin
      drive_select_outputs <= next_selects;
      if (mode == st_compat) begin
        motor_on_first_n_out  <= ~op_reg[OR_MOTOR_FIRST];
        motor_on_second_n_out <= ~op_reg[OR_MOTOR_SECOND];
        // low asks for slow spindle; in the other modes high asks for reduced write current
        reduced_write_current_pin_out <= ~slow_spindle_req_in;
      end else begin
        motor_on_first_n_out          <= 1'b1;
        motor_on_second_n_out         <= 1'b1;
        reduced_write_current_pin_out <= precomp_needed_in;
      end
    end
  end

  // ****************************************
  // mode report
  // ****************************************
  always_ff @(posedge core_clk_in or negedge resetn_in) begin
    if (!resetn_in) begin
      mode_out <= 2'h0;
    end else begin
      unique case (mode)
        st_post_reset: mode_out <= 2'h0;
        st_base:       mode_out <= 2'h1;
        st_special:    mode_out <= 2'h2;
        st_compat:     mode_out <= 2'h3;
      endcase
    end
  end

endmodule

// >>> fdc_host_port_props.sv
// concurrent checks on the host port and mode control outputs
module fdc_host_port_props
  import fdc_port_pkg::*;
(
  input wire logic       core_clk_in,
  input wire logic       resetn_in,
  input wire host_bus_t  host_bus_in,
  input wire logic [7:0] data_in,
  input wire logic [7:0] data_out,
  input wire logic       data_oe_out,
  input wire logic       dma_req_oe_out,
  input wire logic       irq_oe_out,
  input wire logic [7:0] main_status_in,
  input wire logic [7:0] result_byte_in,
  input wire logic [7:0] cmd_byte_out,
  input wire logic       cmd_byte_valid_out,
  input wire logic       data_read_out,
  input wire logic       controller_reset_out,
  input wire logic       ready_change_out,
  input wire logic       precomp_needed_in,
  input wire logic       slow_spindle_req_in,
  input wire logic [3:0] drive_select_outputs,
  input wire logic       motor_on_first_n_out,
  input wire logic       motor_on_second_n_out,
  input wire logic       reduced_write_current_pin_out,
  input wire logic [1:0] mode_out
);
  timeunit 1ns;
  timeprecision 1ps;
  default clocking cb @(posedge core_clk_in);
  endclocking
  default disable iff (!resetn_in);
  logic rd_acc;  // chip-selected read, write strobe idle
  logic wr_acc;  // chip-selected data register, read strobe idle
  assign rd_acc = !host_bus_in.cs_n && !host_bus_in.rd_n && host_bus_in.wr_n;
  assign wr_acc = !host_bus_in.cs_n && host_bus_in.rd_n
                  && host_bus_in.reg_select_line;
  sequence s_status_rd;
    rd_acc && !host_bus_in.reg_select_line;
  endsequence
  sequence s_data_rd;
    rd_acc && host_bus_in.reg_select_line;
  endsequence
  sequence s_data_wr;
    wr_acc && $fell(host_bus_in.wr_n);
  endsequence
  a_status_read_data:
    assert property (s_status_rd |=> data_oe_out
      && data_out == $past(main_status_in))
    else $error("status byte missing on read");
  a_data_read_byte:
    assert property (s_data_rd |=> data_oe_out
      && data_out == $past(result_byte_in))
    else $error("data byte missing on read");
  a_data_read_pulse:
    assert property (s_data_rd ##0 $fell(host_bus_in.rd_n)
      |=> data_read_out)
    else $error("data read pulse missing");
  a_write_capture_byte:
    assert property (s_data_wr |=> cmd_byte_valid_out
      && cmd_byte_out == $past(data_in))
    else $error("written byte not captured");
  a_post_reset_quiet:
    assert property (mode_out == 2'h0 |-> !dma_req_oe_out && !irq_oe_out
      && controller_reset_out)
    else $error("outputs driven before first access");
  a_compat_upper_off:
    assert property (mode_out == 2'h3 && $past(mode_out) == 2'h3
      |-> drive_select_outputs[3:2] == 2'h0)
    else $error("upper drive selects active in compat");
  a_precomp_pin_follow:
    assert property (mode_out inside {2'h1, 2'h2} && $stable(mode_out)
      |-> reduced_write_current_pin_out == $past(precomp_needed_in))
    else $error("write current pin ignores precomp");
  a_spindle_slow_low:
    assert property (mode_out == 2'h3 && $stable(mode_out)
      |-> reduced_write_current_pin_out == !$past(slow_spindle_req_in))
    else $error("spindle slow pin not active low");
  a_motor_outside_compat:
    assert property (mode_out != 2'h3
      |-> motor_on_first_n_out && motor_on_second_n_out)
    else $error("motor on outside compat mode");
  a_ready_single_pulse:
    assert property (ready_change_out |=> !ready_change_out [*8])
    else $error("ready change pulsed twice");
endmodule

// >>> host_cpu_model.sv
// host processor model driving the register port strobes
module host_cpu_model
  import fdc_port_pkg::*;
(
  input  wire logic       core_clk_in,
  input  wire logic [7:0] data_out,
  output host_bus_t       host_bus_in,
  output logic      [7:0] data_in
);
  timeunit 1ns;
  timeprecision 1ps;
  initial begin
    host_bus_in = 6'h3F;  // all strobes idle
    data_in = 8'h00;
  end
  // one access: held over the take edge and the answer edge
  task automatic access(input logic [5:0] b, input logic [7:0] d,
                        output logic [7:0] q);
    @(negedge core_clk_in);
    host_bus_in <= b;
    data_in <= d;
    repeat (2) @(negedge core_clk_in);
    q = data_out;
    host_bus_in <= 6'h3F;
    data_in <= ~d;  // released bus never keeps the old byte
    @(negedge core_clk_in);
  endtask
endmodule

// >>> fdc_host_port_bench.sv
// self-checking bench of the floppy host port and mode control
module fdc_host_port_bench
  import fdc_port_pkg::*;
;
  timeunit 1ns;
  timeprecision 1ps;
  logic            core_clk_in = 1'b0;
  logic            resetn_in = 1'b0;
  host_bus_t       host_bus;
  logic      [7:0] data_in, data_out, q, cmd_byte;
  logic      [7:0] status = 8'hA5, result = 8'h3C;
  logic            idle = 1'b1, rw_cmd = 1'b0, mini = 1'b0;
  logic            precomp = 1'b1, core_irq = 1'b1, dack_in = 1'b0;
  logic            slow_req = 1'b0, core_dma = 1'b1;
  logic      [1:0] unit = 2'h0, mode;
  logic      [3:0] sel;
  logic            irq, dack_n, ctl_rst, rdy, m1_n, m2_n, dma, dma_oe, irq_oe;
  int              num_errors = 0;
  int              checks = 0;
  always #2 core_clk_in = ~core_clk_in;
  fdc_host_port #(.POLL_STEP_CYCLES(8), .POLL_STEP_CYCLES_MINI(16)) dut (
    .core_clk_in, .resetn_in, .host_bus_in(host_bus), .data_in,
    .data_out, .data_oe_out(), .dma_req_out(dma), .dma_req_oe_out(dma_oe),
    .irq_out(irq), .irq_oe_out(irq_oe), .dack_n_in(dack_in),
    .main_status_in(status), .result_byte_in(result),
    .cmd_byte_out(cmd_byte), .cmd_byte_valid_out(), .data_read_out(),
    .core_dma_req_in(core_dma), .core_irq_in(core_irq), .dack_n_out(dack_n),
    .controller_reset_out(ctl_rst), .ready_change_out(rdy),
    .core_idle_in(idle), .rw_command_in(rw_cmd), .mini_floppy_in(mini),
    .unit_select_in(unit), .precomp_needed_in(precomp),
    .slow_spindle_req_in(slow_req), .drive_select_outputs(sel),
    .motor_on_first_n_out(m1_n), .motor_on_second_n_out(m2_n),
    .reduced_write_current_pin_out(), .mode_out(mode));
  host_cpu_model host (.core_clk_in, .data_out, .host_bus_in(host_bus),
    .data_in);
  task automatic chk(input string what, input logic [7:0] seen, exp);
    checks++;
    if (seen !== exp) begin
      num_errors++;
      $display("Error %s expected %h seen %h", what, exp, seen);
    end
  endtask
  task automatic end_sim();
    $display("checks %0d errors %0d", checks, num_errors);
    if (num_errors == 0 && checks > 0)
      $display("== PASSED ==");
    else
      $display("== FAILED ==");
    $finish;
  endtask
  task automatic hard_reset();
    @(negedge core_clk_in);
    resetn_in <= 1'b0;
    repeat (2) @(negedge core_clk_in);
    resetn_in <= 1'b1;
  endtask
  task automatic op_load(input logic [7:0] v);
    host.access(6'h31, v, q);  // selects settle one cycle after the take
  endtask
  // follow one polling round on the selects, with a bounded wait
  task automatic poll_round(input logic [7:0] slot_len);
    int n, chg, twos, pulses;
    logic [3:0] last;
    logic [15:0] order;
    last = sel;
    {chg, twos, pulses, order} = '0;
    for (n = 0; n < 160 && chg < 4; n++) begin
      @(negedge core_clk_in);
      pulses += int'(rdy);
      twos += int'(sel === 4'h2);
      if (sel !== last) begin
        order = {order[11:0], sel};
        chg++;
      end
      last = sel;
    end
    if (chg < 4) begin
      num_errors++;
      end_sim();
    end
    repeat (6) @(negedge core_clk_in) pulses += int'(rdy);
    chk("poll order", order[15:8], 8'h28);
    chk("poll tail", order[7:0], 8'h41);
    chk("slot", 8'(twos), slot_len);
    chk("ready", 8'(pulses), 8'h01);
  endtask
  // base entry, register decode and drive polling
  task automatic t_base();
    hard_reset();
    host.access(6'h0B, 8'h00, q);
    chk("status", q, 8'hA5);
    chk("mode", 8'(mode), 8'h01);
    chk("irq dma oe", 8'({irq_oe, dma_oe}), 8'h03);
    poll_round(8'h08);
    host.access(6'h0F, 8'h00, q);
    chk("data", q, 8'h3C);
    host.access(6'h17, 8'h5A, q);
    chk("cmd", cmd_byte, 8'h5A);
    chk("irq dma", 8'({irq, dma}), 8'h03);
    $display("test base done");
  endtask
  // compat entry by operations write and its buffered bits
  task automatic t_compat();
    hard_reset();
    slow_req = 1'b1;
    op_load(8'h3C);
    chk("mode", 8'(mode), 8'h03);
    chk("sel", 8'(sel), 8'h01);
    chk("motors", 8'({m1_n, m2_n}), 8'h00);
    chk("gate", 8'({irq, dma, dack_n}), 8'h06);
    op_load(8'h3D);
    chk("sel", 8'(sel), 8'h02);
    op_load(8'h3E);
    chk("sel", 8'(sel), 8'h00);
    op_load(8'h34);
    chk("gate", 8'({irq, dma, dack_n}), 8'h01);
    op_load(8'h38);
    chk("rst", 8'({ctl_rst, mode}), 8'h07);
    $display("test compat done");
  endtask
  // special entry, refused pattern, mini polling and exit to compat
  task automatic t_special();
    hard_reset();
    precomp = 1'b0;
    mini = 1'b1;
    op_load(8'h80);
    host.access(6'h2A, 8'h00, q);
    chk("mode", 8'(mode), 8'h02);
    op_load(8'h94);
    host.access(6'h2A, 8'h00, q);
    chk("mode", 8'(mode), 8'h02);
    op_load(8'h04);
    chk("rst", 8'(ctl_rst), 8'h00);
    poll_round(8'h10);
    rw_cmd = 1'b1;
    unit = 2'h3;
    repeat (2) @(negedge core_clk_in);
    chk("unit sel", 8'(sel), 8'h08);
    rw_cmd = 1'b0;
    op_load(8'h00);
    host.access(6'h2A, 8'h00, q);
    chk("mode", 8'(mode), 8'h03);
    $display("test special done");
  endtask
  initial begin
    t_base();
    t_compat();
    t_special();
    end_sim();
  end
endmodule
bind fdc_host_port fdc_host_port_props props (
  .core_clk_in, .resetn_in, .host_bus_in, .data_in, .data_out,
  .data_oe_out, .dma_req_oe_out, .irq_oe_out, .main_status_in,
  .result_byte_in, .cmd_byte_out, .cmd_byte_valid_out, .data_read_out,
  .controller_reset_out, .ready_change_out, .precomp_needed_in,
  .slow_spindle_req_in, .drive_select_outputs, .motor_on_first_n_out,
  .motor_on_second_n_out, .reduced_write_current_pin_out, .mode_out);
